//--- pkg/scm_pkg.sv
// Shared constants and types for the signal conflict monitor fault logic
package scm_pkg;

  localparam int CH_NUM   = 18;
  localparam int CLK_KHZ  = 25000;
  localparam int TMR_W    = 26;
  localparam int VRMS_W   = 8;

  // Fault timings in ms, nominal figures
  localparam int RF_ON_MS   = 1350;
  localparam int RF_OFF_MS  = 850;
  localparam int WD_ON_MS   = 1000;
  localparam int WD_OFF_MS  = 1500;
  localparam int BO_ON_MS   = 400;
  localparam int BO_OFF_MS  = 80;

  localparam int RF_ON_CYC  = RF_ON_MS * CLK_KHZ;
  localparam int RF_OFF_CYC = RF_OFF_MS * CLK_KHZ;
  localparam int WD_ON_CYC  = WD_ON_MS * CLK_KHZ;
  localparam int WD_OFF_CYC = WD_OFF_MS * CLK_KHZ;
  localparam int BO_ON_CYC  = BO_ON_MS * CLK_KHZ;
  localparam int BO_OFF_CYC = BO_OFF_MS * CLK_KHZ;

  // Line voltage thresholds in Vrms
  localparam logic [VRMS_W-1:0] VRMS_DROP_BO  = 8'h62;
  localparam logic [VRMS_W-1:0] VRMS_REST_BO  = 8'h67;
  localparam logic [VRMS_W-1:0] VRMS_DROP_STD = 8'h5C;
  localparam logic [VRMS_W-1:0] VRMS_REST_STD = 8'h62;

  typedef enum logic [1:0] {
    ST_LINE_OK  = 2'b00,
    ST_LINE_LOW = 2'b01,
    ST_BROWNOUT = 2'b10
  } scm_line_t;

endpackage : scm_pkg

//--- verilog/scm_timer.sv
// Saturating timeout counter that runs while enabled
`timescale 1ns/10ps
`default_nettype none
module scm_timer
  import scm_pkg::*;
#(
  parameter int W = TMR_W
) (
  input  wire logic         core_clk_i,
  input  wire logic         srst_i,
  input  wire logic         run_i,
  input  wire logic [W-1:0] limit_i,
  output logic              expired_o
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         exp_q;
  logic         exp_d;

  always_comb begin
    if (!run_i) begin
      cnt_d = '0;
    end else if (cnt_q >= limit_i) begin
      cnt_d = cnt_q;
    end else begin
      cnt_d = cnt_q + W'(1);
    end
    exp_d = run_i && (cnt_d >= limit_i);
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cnt_q <= '0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end

  assign expired_o = exp_q;

endmodule : scm_timer
`default_nettype wire

//--- verilog/scm_faults.sv
// Fault supervision, latching and indication for an 18-channel conflict monitor
//
// How it works
// R1 - Eighteen channels, each with qualified green, yellow and red inputs.
// R2 - Missing card forces fault until card present and reset arrives.
// R3 - Conflict records active channels; other channel faults record failed channels.
// R4 - Fault marks and captured channel status freeze until reset.
// R5 - Separate indicators for power, DC, watchdog, conflict, red, dual, clearance, card, diag.
// R6 - Red, yellow, green status output per channel, fifty-four in all.
// R7 - Red-fail timeout 1350 ms with switch on, 850 ms off.
// R8 - Watchdog timeout 1.0 s with switch on, 1.5 s off.
// R9 - Brown-out qualification 400 ms with option, 80 ms without.
// R10 - Option selects dropout/restore 98/103 Vrms, else 92/98 Vrms.
// R11 - Latch option off: watchdog fault cleared by any power event.
// R12 - Latch option on: watchdog fault kept until explicit reset.
// R13 - Relay-common input active when high; polarity jumper inverts it.
// R14 - Fault mode holds until front-panel or remote reset.
// R15 - Red-fail monitoring needs red enable, no special function, relay-common inactive.
// R16 - Inputs are qualified levels; timeouts counted in system clock cycles.
`timescale 1ns/10ps
`default_nettype none
module scm_faults
  import scm_pkg::*;
#(
  parameter int              N_CH       = CH_NUM,
  parameter logic [TMR_W-1:0] P_RF_ON   = TMR_W'(RF_ON_CYC),
  parameter logic [TMR_W-1:0] P_RF_OFF  = TMR_W'(RF_OFF_CYC),
  parameter logic [TMR_W-1:0] P_WD_ON   = TMR_W'(WD_ON_CYC),
  parameter logic [TMR_W-1:0] P_WD_OFF  = TMR_W'(WD_OFF_CYC),
  parameter logic [TMR_W-1:0] P_BO_ON   = TMR_W'(BO_ON_CYC),
  parameter logic [TMR_W-1:0] P_BO_OFF  = TMR_W'(BO_OFF_CYC)
) (
  input  wire logic              core_clk_i,
  input  wire logic              srst_i,
  input  wire logic [N_CH-1:0]   ch_grn_i,
  input  wire logic [N_CH-1:0]   ch_yel_i,
  input  wire logic [N_CH-1:0]   ch_red_i,
  input  wire logic [N_CH-1:0]   rf_ch_en_i,
  input  wire logic              card_present_i,
  input  wire logic              panel_reset_i,
  input  wire logic              remote_reset_i,
  input  wire logic              red_enable_i,
  input  wire logic              special_func1_i,
  input  wire logic              special_func2_i,
  input  wire logic              relay_common_input_i,
  input  wire logic              polarity_jumper_i,
  input  wire logic              rf_timing_sw_i,
  input  wire logic              wd_timing_sw_i,
  input  wire logic              brownout_opt_i,
  input  wire logic              wd_latch_opt_i,
  input  wire logic [VRMS_W-1:0] line_vrms_i,
  input  wire logic              wd_pulse_i,
  input  wire logic              conflict_i,
  input  wire logic [N_CH-1:0]   dual_fail_i,
  input  wire logic [N_CH-1:0]   clear_fail_i,
  input  wire logic              dc_fail_i,
  input  wire logic              diag_fail_i,
  output logic                   fault_mode_o,
  output logic                   ac_power_ind_o,
  output logic                   dc_supply_fault_indicator_o,
  output logic                   watchdog_timeout_indicator_o,
  output logic                   conflict_ind_o,
  output logic                   red_fail_ind_o,
  output logic                   dual_ind_o,
  output logic                   clearance_ind_o,
  output logic                   card_ajar_indicator_o,
  output logic                   diag_fail_ind_o,
  output logic [N_CH-1:0]        ch_red_ind_o,
  output logic [N_CH-1:0]        ch_yel_ind_o,
  output logic [N_CH-1:0]        ch_grn_ind_o,
  output logic [N_CH-1:0]        ch_fault_mark_o
);

  function automatic logic [TMR_W-1:0] sel_cyc(input logic sw,
                                               input logic [TMR_W-1:0] on_v,
                                               input logic [TMR_W-1:0] off_v);
    sel_cyc = sw ? on_v : off_v;
  endfunction : sel_cyc

  ////////////////////////////////////////////////////////////////////////////
  // Qualifiers and timers

  logic            ee_active;
  logic            rf_mon;
  logic            rst_cmd;
  logic [N_CH-1:0] rf_exp;
  logic            wd_exp;
  logic            bo_exp;
  logic            wd_prev_q;
  logic            line_low;
  logic            line_high;
  scm_line_t       bo_q;
  scm_line_t       bo_d;

  assign ee_active = relay_common_input_i ^ polarity_jumper_i;                   // [R13]
  assign rf_mon    = red_enable_i && !special_func1_i && !special_func2_i
                     && !ee_active;                                             // [R15]
  assign rst_cmd   = panel_reset_i || remote_reset_i;                           // [R14]
  assign line_low  = line_vrms_i < (brownout_opt_i ? VRMS_DROP_BO : VRMS_DROP_STD);   // [R10]
  assign line_high = line_vrms_i >= (brownout_opt_i ? VRMS_REST_BO : VRMS_REST_STD);  // [R10]

  for (genvar i = 0; i < N_CH; i++) begin : g_rf
    scm_timer u_rf (
      .core_clk_i (core_clk_i),
      .srst_i     (srst_i),
      .run_i      (rf_mon && rf_ch_en_i[i]
                   && !(ch_grn_i[i] || ch_yel_i[i] || ch_red_i[i])),            // [R1]
      .limit_i    (sel_cyc(rf_timing_sw_i, P_RF_ON, P_RF_OFF)),                 // [R7] [R16]
      .expired_o  (rf_exp[i])
    );
  end

  // Watchdog restarts on each change of the controller pulse
  scm_timer u_wd (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .run_i      ((wd_pulse_i == wd_prev_q) && (bo_q != ST_BROWNOUT)),
    .limit_i    (sel_cyc(wd_timing_sw_i, P_WD_ON, P_WD_OFF)),                   // [R8] [R16]
    .expired_o  (wd_exp)
  );

  scm_timer u_bo (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .run_i      ((bo_q == ST_LINE_LOW) && line_low),
    .limit_i    (sel_cyc(brownout_opt_i, P_BO_ON, P_BO_OFF)),                   // [R9]
    .expired_o  (bo_exp)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Line supervision

  always_comb begin
    case (bo_q)
      ST_LINE_OK:  bo_d = line_low ? ST_LINE_LOW : ST_LINE_OK;
      ST_LINE_LOW: bo_d = !line_low ? ST_LINE_OK :
                          (bo_exp ? ST_BROWNOUT : ST_LINE_LOW);                 // [R9]
      ST_BROWNOUT: bo_d = line_high ? ST_LINE_OK : ST_BROWNOUT;                 // [R10]
      default:     bo_d = ST_LINE_OK;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      bo_q      <= ST_LINE_OK;
      wd_prev_q <= 1'b0;
    end else begin
      bo_q      <= bo_d;
      wd_prev_q <= wd_pulse_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault latches; a new event wins over a reset in the same cycle

  logic            conf_q, rf_q, dual_q, clr_q, card_q, wd_q, dc_q, diag_q, ac_q;
  logic            conf_d, rf_d, dual_d, clr_d, card_d, wd_d, dc_d, diag_d, ac_d;
  logic            fault_q;
  logic            event_any;
  logic [N_CH-1:0] fail_vec;
  logic [N_CH-1:0] mark_q, mark_d;
  logic [N_CH-1:0] cr_q, cy_q, cg_q;
  logic [N_CH-1:0] cr_d, cy_d, cg_d;

  assign fail_vec  = rf_exp | dual_fail_i | clear_fail_i;
  assign event_any = conflict_i || (|fail_vec) || !card_present_i || wd_exp
                     || dc_fail_i || diag_fail_i;

  always_comb begin
    conf_d = conflict_i       || (conf_q && !rst_cmd);                          // [R14]
    rf_d   = (|rf_exp)        || (rf_q   && !rst_cmd);                          // [R7]
    dual_d = (|dual_fail_i)   || (dual_q && !rst_cmd);
    clr_d  = (|clear_fail_i)  || (clr_q  && !rst_cmd);
    dc_d   = dc_fail_i        || (dc_q   && !rst_cmd);                          // [R5]
    diag_d = diag_fail_i      || (diag_q && !rst_cmd);
    card_d = !card_present_i  || (card_q && !rst_cmd);                          // [R2]
    wd_d   = wd_exp || (wd_q && !rst_cmd
                        && (wd_latch_opt_i || bo_q != ST_BROWNOUT));            // [R11] [R12]
    ac_d   = bo_d != ST_BROWNOUT;
    // Capture follows live inputs until the first fault, then freezes
    if (fault_q) begin                                                          // [R4]
      mark_d = mark_q;
      cr_d   = cr_q;
      cy_d   = cy_q;
      cg_d   = cg_q;
    end else begin
      cr_d   = ch_red_i;
      cy_d   = ch_yel_i;
      cg_d   = ch_grn_i;
      if (conflict_i) begin
        mark_d = ch_grn_i | ch_yel_i | ch_red_i;                                // [R3]
      end else begin
        mark_d = fail_vec;                                                      // [R3]
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      conf_q  <= 1'b0;
      rf_q    <= 1'b0;
      dual_q  <= 1'b0;
      clr_q   <= 1'b0;
      dc_q    <= 1'b0;
      diag_q  <= 1'b0;
      card_q  <= 1'b0;
      wd_q    <= 1'b0;
      ac_q    <= 1'b1;
      fault_q <= 1'b0;
      mark_q  <= '0;
      cr_q    <= '0;
      cy_q    <= '0;
      cg_q    <= '0;
    end else begin
      conf_q  <= conf_d;
      rf_q    <= rf_d;
      dual_q  <= dual_d;
      clr_q   <= clr_d;
      dc_q    <= dc_d;
      diag_q  <= diag_d;
      card_q  <= card_d;
      wd_q    <= wd_d;
      ac_q    <= ac_d;
      fault_q <= conf_d || rf_d || dual_d || clr_d || dc_d || diag_d
                 || card_d || wd_d;                                             // [R14]
      mark_q  <= mark_d;
      cr_q    <= cr_d;
      cy_q    <= cy_d;
      cg_q    <= cg_d;
    end
  end

  assign fault_mode_o                 = fault_q;
  assign ac_power_ind_o               = ac_q;                                   // [R5]
  assign dc_supply_fault_indicator_o  = dc_q;
  assign watchdog_timeout_indicator_o = wd_q;
  assign conflict_ind_o               = conf_q;
  assign red_fail_ind_o               = rf_q;
  assign dual_ind_o                   = dual_q;
  assign clearance_ind_o              = clr_q;
  assign card_ajar_indicator_o        = card_q;
  assign diag_fail_ind_o              = diag_q;
  assign ch_red_ind_o                 = cr_q;                                   // [R6]
  assign ch_yel_ind_o                 = cy_q;                                   // [R6]
  assign ch_grn_ind_o                 = cg_q;                                   // [R6]
  assign ch_fault_mark_o              = mark_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  AST_CARD_SET: assert property (@(posedge core_clk_i) disable iff (srst_i) // [R2]
    !card_present_i |=> card_ajar_indicator_o && fault_mode_o)
    else $error("card absence did not force fault mode");

  AST_CARD_HOLD: assert property (@(posedge core_clk_i) disable iff (srst_i) // [R2]
    (card_ajar_indicator_o && !rst_cmd) |=> card_ajar_indicator_o)
    else $error("card fault cleared without reset");

  AST_MARK_CONF: assert property (@(posedge core_clk_i) disable iff (srst_i) // [R3]
    (!fault_mode_o && conflict_i)
      |=> ch_fault_mark_o == ($past(ch_grn_i) | $past(ch_yel_i) | $past(ch_red_i)))
    else $error("conflict did not record active channels");

  AST_FREEZE: assert property (@(posedge core_clk_i) disable iff (srst_i) // [R4]
    (fault_mode_o && !rst_cmd) |=> $stable(ch_red_ind_o) && $stable(ch_fault_mark_o))
    else $error("captured status changed during fault mode");

  AST_DC_IND: assert property (@(posedge core_clk_i) disable iff (srst_i) // [R5]
    $rose(dc_fail_i) |=> dc_supply_fault_indicator_o && fault_mode_o)
    else $error("dc fault indicator not raised");

  AST_RF_LATCH: assert property (@(posedge core_clk_i) disable iff (srst_i) // [R7]
    (|rf_exp) |=> red_fail_ind_o)
    else $error("red fail expiry not latched");

  AST_RF_GATE: assert property (@(posedge core_clk_i) disable iff (srst_i) // [R15]
    !rf_mon |=> rf_exp == '0)
    else $error("red fail timing ran while monitoring disabled");

  AST_BO_ABORT: assert property (@(posedge core_clk_i) disable iff (srst_i) // [R9]
    (bo_q == ST_LINE_LOW && !line_low) |=> bo_q == ST_LINE_OK && ac_power_ind_o)
    else $error("brief dip not abandoned");

  AST_DROP: assert property (@(posedge core_clk_i) disable iff (srst_i) // [R10]
    (bo_q == ST_LINE_OK && brownout_opt_i && line_vrms_i < VRMS_DROP_BO)
      |=> bo_q == ST_LINE_LOW)
    else $error("dropout threshold not applied");

  AST_WD_UNLATCH: assert property (@(posedge core_clk_i) disable iff (srst_i) // [R11]
    (!wd_latch_opt_i && bo_q == ST_BROWNOUT && !wd_exp) |=> !watchdog_timeout_indicator_o)
    else $error("watchdog fault survived a power event");

  AST_WD_LATCH: assert property (@(posedge core_clk_i) disable iff (srst_i) // [R12]
    (wd_latch_opt_i && watchdog_timeout_indicator_o && !rst_cmd)
      |=> watchdog_timeout_indicator_o)
    else $error("latched watchdog fault cleared without reset");

  AST_RESET: assert property (@(posedge core_clk_i) disable iff (srst_i) // [R14]
    (rst_cmd && !event_any && !(|rf_exp) && !wd_exp) |=> !fault_mode_o)
    else $error("reset did not clear fault mode");

endmodule : scm_faults
`default_nettype wire

//--- verif/scm_cabinet_model.sv
// Cabinet load switches and controller watchdog output model
`timescale 1ns/10ps
`default_nettype none
module scm_cabinet_model
  import scm_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              srst_i,
  input  wire logic [CH_NUM-1:0] grn_set_i,
  input  wire logic [CH_NUM-1:0] yel_set_i,
  input  wire logic [CH_NUM-1:0] red_set_i,
  input  wire logic              wd_alive_i,
  output logic      [CH_NUM-1:0] ch_grn_o,
  output logic      [CH_NUM-1:0] ch_yel_o,
  output logic      [CH_NUM-1:0] ch_red_o,
  output logic                   wd_pulse_o
);
  logic [3*CH_NUM-1:0] field_q;
  logic [3*CH_NUM-1:0] field_d;
  logic                pulse_q;
  logic                pulse_d;

  ////////////////////////////////////////////////////////////////////////////////
  // Qualified field levels, one cycle of switch lag; watchdog toggles while alive
  always_comb begin
    field_d = {grn_set_i, yel_set_i, red_set_i};
    pulse_d = wd_alive_i ? ~pulse_q : pulse_q;
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      field_q <= '0;
      pulse_q <= 1'b0;
    end else begin
      field_q <= field_d;
      pulse_q <= pulse_d;
    end
  end

  assign {ch_grn_o, ch_yel_o, ch_red_o} = field_q;
  assign wd_pulse_o = pulse_q;
endmodule : scm_cabinet_model
`default_nettype wire

//--- verif/scm_faults_test.sv
// Self-checking bench for the conflict monitor fault logic
`timescale 1ns/10ps
`default_nettype none
module scm_faults_test
  import scm_pkg::*;
;
  localparam int RF_ON_L = 20, RF_OFF_L = 12, WD_ON_L = 16, WD_OFF_L = 24;
  localparam int BO_ON_L = 8, BO_OFF_L = 4;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [CH_NUM-1:0] grn_set, yel_set, red_set, rf_ch_en, dual_fail, clear_fail;
  logic [CH_NUM-1:0] ch_grn, ch_yel, ch_red, red_ind, yel_ind, grn_ind, mark;
  logic card_present, panel_reset, remote_reset, red_enable, sf1, sf2, relay_common, jumper;
  logic rf_sw, wd_sw, bo_opt, wd_latch, wd_alive, wd_pulse, conflict, dc_fail, diag_fail;
  logic [VRMS_W-1:0] line_vrms;
  logic fault_mode, ac_ind;
  wire logic [7:0] flags;
  int mismatches = 0;
  int total_checks = 0;

  always #20 core_clk = ~core_clk;

  scm_cabinet_model i_cab (.core_clk_i(core_clk), .srst_i(srst), .grn_set_i(grn_set),
    .yel_set_i(yel_set), .red_set_i(red_set), .wd_alive_i(wd_alive), .ch_grn_o(ch_grn),
    .ch_yel_o(ch_yel), .ch_red_o(ch_red), .wd_pulse_o(wd_pulse));

  scm_faults #(.P_RF_ON(TMR_W'(RF_ON_L)), .P_RF_OFF(TMR_W'(RF_OFF_L)),
    .P_WD_ON(TMR_W'(WD_ON_L)), .P_WD_OFF(TMR_W'(WD_OFF_L)),
    .P_BO_ON(TMR_W'(BO_ON_L)), .P_BO_OFF(TMR_W'(BO_OFF_L))) i_dut (.core_clk_i(core_clk),
    .srst_i(srst),
    .ch_grn_i(ch_grn), .ch_yel_i(ch_yel), .ch_red_i(ch_red), .rf_ch_en_i(rf_ch_en),
    .card_present_i(card_present), .panel_reset_i(panel_reset),
    .remote_reset_i(remote_reset), .red_enable_i(red_enable), .special_func1_i(sf1),
    .special_func2_i(sf2), .relay_common_input_i(relay_common), .polarity_jumper_i(jumper),
    .rf_timing_sw_i(rf_sw), .wd_timing_sw_i(wd_sw), .brownout_opt_i(bo_opt),
    .wd_latch_opt_i(wd_latch), .line_vrms_i(line_vrms), .wd_pulse_i(wd_pulse),
    .conflict_i(conflict), .dual_fail_i(dual_fail), .clear_fail_i(clear_fail),
    .dc_fail_i(dc_fail), .diag_fail_i(diag_fail), .fault_mode_o(fault_mode),
    .ac_power_ind_o(ac_ind), .dc_supply_fault_indicator_o(flags[7]),
    .watchdog_timeout_indicator_o(flags[6]), .conflict_ind_o(flags[5]),
    .red_fail_ind_o(flags[4]), .dual_ind_o(flags[3]), .clearance_ind_o(flags[2]),
    .card_ajar_indicator_o(flags[1]), .diag_fail_ind_o(flags[0]), .ch_red_ind_o(red_ind),
    .ch_yel_ind_o(yel_ind), .ch_grn_ind_o(grn_ind), .ch_fault_mark_o(mark));

  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic step(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : step

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic clr();
    panel_reset = 1'b1;
    step(1);
    panel_reset = 1'b0;
    step(1);
  endtask : clr

  // Counts cycles until the red-fail or watchdog flag rises or ac_ind drops, then checks the span
  task automatic timed(input int sel, input int lim, input int slack);
    int k;
    k = 0;
    while (k < 200 && !((sel == 0 && flags[4] === 1'b1) || (sel == 1 && flags[6] === 1'b1)
           || (sel == 2 && ac_ind === 1'b0))) begin
      step(1);
      k++;
    end
    check(64'(k >= lim && k <= lim + slack), 64'h1);
  endtask : timed

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  initial begin
    repeat (3000) @(posedge core_clk);
    mismatches++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    {grn_set, yel_set, red_set, rf_ch_en, dual_fail, clear_fail} = '0;
    {panel_reset, remote_reset, red_enable, sf1, sf2, relay_common, jumper} = '0;
    {rf_sw, wd_sw, bo_opt, wd_latch, conflict, dc_fail, diag_fail} = '0;
    card_present = 1'b1;
    wd_alive = 1'b1;
    line_vrms = 8'h78;
    repeat (20) @(posedge core_clk);
    #1 srst = 1'b0;
    step(2);
    check(flags, 8'h00);
    check(ac_ind, 1'b1);
    // Conflict capture, freeze and release
    grn_set = 18'h0_0005;
    yel_set = 18'h0_0030;
    red_set = 18'h2_0C00;
    step(3);
    check(grn_ind, 18'h0_0005);
    conflict = 1'b1;
    step(1);
    conflict = 1'b0;
    check(flags, 8'h20);
    check(mark, 18'h2_0C35);
    grn_set = '0;
    red_set = 18'h3_FFFF;
    step(4);
    check({red_ind, yel_ind, grn_ind}, {18'h2_0C00, 18'h0_0030, 18'h0_0005});
    check(fault_mode, 1'b1);
    clr();
    check({fault_mode, mark}, 19'h0_0000);
    step(2);
    check(red_ind, 18'h3_FFFF);
    // Per-channel and unit events
    for (int k = 0; k < 4; k++) begin
      dc_fail = (k == 0);
      dual_fail = (k == 1) ? 18'h0_0020 : 18'h0_0000;
      clear_fail = (k == 2) ? 18'h0_0080 : 18'h0_0000;
      diag_fail = (k == 3);
      step(1);
      {dc_fail, diag_fail, dual_fail, clear_fail} = '0;
      check(flags, (k == 0) ? 8'h80 : (k == 1) ? 8'h08 : (k == 2) ? 8'h04 : 8'h01);
      check(mark, (k == 1) ? 18'h0_0020 : (k == 2) ? 18'h0_0080 : 18'h0_0000);
      clr();
    end
    // Card absence holds until present and reset
    card_present = 1'b0;
    step(2);
    check({fault_mode, flags}, 9'h102);
    clr();
    check(flags[1], 1'b1);
    card_present = 1'b1;
    step(2);
    check(fault_mode, 1'b1);
    remote_reset = 1'b1;
    step(1);
    remote_reset = 1'b0;
    step(1);
    check({fault_mode, flags}, 9'h000);
    // Red fail blocked by each special function and by relay-common, then timed both ways
    {grn_set, red_set} = '0;
    rf_ch_en = 18'h0_0001;
    for (int k = 0; k < 3; k++) begin
      red_enable = 1'b1;
      sf1 = (k == 0);
      sf2 = (k == 1);
      relay_common = (k == 2);
      step(30);
      check(flags[4], 1'b0);
    end
    for (int k = 0; k < 2; k++) begin
      rf_sw = (k == 0);
      {relay_common, jumper, red_enable} = 3'b111;
      timed(0, k ? RF_OFF_L : RF_ON_L, 2);
      check(mark, 18'h0_0001);
      red_enable = 1'b0;
      step(1);
      clr();
    end
    // Watchdog timing both ways
    for (int k = 0; k < 2; k++) begin
      wd_sw = (k == 0);
      wd_alive = 1'b0;
      timed(1, k ? WD_OFF_L : WD_ON_L, 4);
      wd_alive = 1'b1;
      step(2);
      clr();
    end
    // Latch off: brown-out clears the watchdog fault
    wd_sw = 1'b1;
    wd_alive = 1'b0;
    timed(1, WD_ON_L, 4);
    wd_alive = 1'b1;
    bo_opt = 1'b1;
    line_vrms = 8'h61;
    timed(2, BO_ON_L, 2);
    step(1);
    check(flags[6], 1'b0);
    line_vrms = 8'h66;
    step(3);
    check(ac_ind, 1'b0);
    line_vrms = 8'h67;
    step(2);
    check(ac_ind, 1'b1);
    clr();
    // Latch on: fault survives brown-out until reset
    wd_latch = 1'b1;
    wd_alive = 1'b0;
    timed(1, WD_ON_L, 4);
    wd_alive = 1'b1;
    bo_opt = 1'b0;
    line_vrms = 8'h5C;
    step(10);
    check(ac_ind, 1'b1);
    // Brief dip shorter than the qualification time is abandoned
    line_vrms = 8'h5B;
    step(2);
    line_vrms = 8'h5C;
    step(8);
    check(ac_ind, 1'b1);
    line_vrms = 8'h5B;
    timed(2, BO_OFF_L, 2);
    check(flags[6], 1'b1);
    line_vrms = 8'h61;
    step(3);
    check(ac_ind, 1'b0);
    line_vrms = 8'h62;
    step(2);
    check(ac_ind, 1'b1);
    clr();
    check({fault_mode, flags}, 9'h000);
    summarize();
  end
endmodule : scm_faults_test
`default_nettype wire
